// File: common/mcmd_cfg.svh
`ifndef MCMD_CFG_SVH
`define MCMD_CFG_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define MCMD_OFS_CTRL 5'h00
`define MCMD_OFS_THR 5'h04
`define MCMD_OFS_RES 5'h08
`define MCMD_OFS_ERR 5'h0C
`define MCMD_OFS_VAR 5'h10

// ****************************************************
// Reset values
// ****************************************************
`define MCMD_CTRL_RST 5'h00
`define MCMD_THR_RST 8'h03

// ****************************************************
// Search geometry and decision constants
// ****************************************************
// 15 rows by 16 columns of candidates, row-major
`define MCMD_CAND_LAST 8'hEF
`define MCMD_ZERO_CAND 8'h78
`define MCMD_VY_OFS 4'h7
`define MCMD_VX_OFS 4'h8
`define MCMD_BEST_INIT 14'h3FFF
`define MCMD_VAR_DONE 9'h100
// Forced intra period in macroblocks
`define MCMD_INTRA_PERIOD 6'h3D
// Motion compensation boundary: gap >= zero/8 + offset
`define MCMD_MC_SHIFT 3
`define MCMD_MC_OFS 14'h0010
// Host instruction byte: read-mode bit
`define MCMD_HI_RD_BIT 7
// AXI responses
`define MCMD_RESP_OKAY 2'h0
`define MCMD_RESP_SLVERR 2'h2

`endif

// File: common/mcmd_pkg.sv
package mcmd_pkg;

  // One current / previous-frame pixel pair
  typedef struct packed {
    logic [7:0] cur;
    logic [7:0] ref_px;
  } mcmd_pair_t;

  // Host control bits, bit 0 first from the bottom
  typedef struct packed {
    logic filt_off;
    logic skip_pic;
    logic fix_mb;
    logic force_intra;
    logic force_inter;
  } mcmd_ctrl_t;

  // Per-macroblock decision
  typedef struct packed {
    logic intra;
    logic mc;
    logic filt;
    logic [3:0] mv_y;
    logic [3:0] mv_x;
    logic [13:0] best;
    logic [13:0] zero;
    logic [13:0] sel;
    logic [13:0] var_e;
  } mcmd_dec_t;

  // 3x3 neighbourhood, index row*3+col
  typedef logic [8:0][7:0] mcmd_win_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_SRCH = 4'h2,
    S_VAR = 4'h4,
    S_DEC = 4'h8
  } mcmd_state_t;

endpackage

// File: verilog/mcmd_pix_mem.sv
`timescale 1ns/1ns
module mcmd_pix_mem (
  // Clock
  input wire logic aclk,
  // Write port
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [7:0] raddr,
  output logic [7:0] rdata_q
);
  logic [7:0] mem [0:255];

  // Write side
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read, one cycle latency
  always_ff @(posedge aclk) begin
    rdata_q <= mem[raddr];
  end
endmodule

// File: verilog/mcmd_loop_filt.sv
`timescale 1ns/1ns
module mcmd_loop_filt (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Window in
  input wire logic in_valid,
  input wire mcmd_pkg::mcmd_win_t win,
  input wire logic edge_h,
  input wire logic edge_v,
  // Pixel out
  output logic out_valid_q,
  output logic [7:0] pix_q
);
  import mcmd_pkg::*;
  logic [2:0][9:0] h;
  logic [11:0] v;
  logic [11:0] vr;

  // Separable kernel, pass-through on edges
  always_comb begin
    for (int r = 0; r < 3; r++) begin
      if (edge_h) begin
        h[r] = {win[r*3+1], 2'h0};
      end else begin
        h[r] = {2'h0, win[r*3]} + {1'h0, win[r*3+1], 1'h0}
             + {2'h0, win[r*3+2]};
      end
    end
    if (edge_v) begin
      v = {h[1], 2'h0};
    end else begin
      v = {2'h0, h[0]} + {1'h0, h[1], 1'h0} + {2'h0, h[2]};
    end
    vr = v + 12'h008;
  end

  // Rounded, normalised output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid_q <= 1'b0;
      pix_q <= 8'h00;
    end else begin
      out_valid_q <= in_valid;
      if (in_valid) begin
        pix_q <= vr[11:4];
      end
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_edge_pass;
    in_valid && edge_h && edge_v |=> pix_q == $past(win[4]);
  endproperty
  a_edge_pass: assert property (p_edge_pass)
    else $error("edge pixel not passed through");
endmodule

// File: verilog/mcmd_top.sv
`timescale 1ns/1ns
`include "mcmd_cfg.svh"
// Overview of operation
// - Error summed for all 15x16 positions, rows -7..+7, columns -8..+7
// - Two low pixel bits dropped, so every candidate sum fits 14 bits
// - Smallest error, its position and zero-displacement error kept
// - Compensated: best error drives inter/intra; else zero error
// - Variance: sum of |pixel - mean|, 16 bits cut to 14
// - Error top 8 bits below threshold (default 3) means inter
// - Otherwise inter only if variance at least the error, else intra
// - Every 61st macroblock is forced intra
// - Forced intra counter halted while fix or skip is set
// - Host may override; host forced inter beats periodic intra
// - Compensated inter prediction is filtered unless host disables it
// - Filter kernel 1-2-1 both ways, 0-1-0 on macroblock edges
// - Host bytes move on strobe rising edge while enable is high
// - Data-select high marks data, low marks an instruction
// - All decision logic runs on the one system clock
module mcmd_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [4:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [4:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Search stream
  input wire logic mb_start,
  input wire logic me_valid,
  input wire mcmd_pkg::mcmd_pair_t me_pair,
  output logic me_ready,
  // Decision
  output logic dec_valid,
  output mcmd_pkg::mcmd_dec_t dec_q,
  // Loop filter stream
  input wire logic lf_valid,
  input wire mcmd_pkg::mcmd_win_t lf_win,
  input wire logic lf_edge_h,
  input wire logic lf_edge_v,
  output logic lf_out_valid,
  output logic [7:0] lf_pix,
  // Host control port
  input wire logic [7:0] host_ctrl_bus_in,
  output logic [7:0] host_ctrl_bus_out,
  output logic host_ctrl_bus_oe,
  input wire logic host_ctrl_strobe,
  input wire logic host_ctrl_enable,
  input wire logic host_data_not_instr
);
  import mcmd_pkg::*;

  mcmd_state_t state_q;
  mcmd_ctrl_t ctrl_q;
  logic [7:0] thresh_q, pix_cnt_q, cand_q, best_idx_q, mem_rd, mean, vd;
  logic [13:0] acc_q, best_q, zero_q, cand_sum, sel_w, zero_gap, var14;
  logic [15:0] sum_cur_q, var_acc_q;
  logic [8:0] var_cnt_q;
  logic [5:0] mb_cnt_q, cur6, ref6, ad;
  logic take, cand_end, rd_vld_q, mc_w, comp_inter_w, fi_dis_w;
  logic periodic_w, intra_w, mb_go;

  // ****************************************************
  // Block matching search
  // ****************************************************
  assign me_ready = state_q == S_SRCH;
  assign take = me_valid && me_ready;
  assign cand_end = take && pix_cnt_q == 8'hFF;
  assign mb_go = state_q == S_IDLE && mb_start;
  assign cur6 = me_pair.cur[7:2];
  assign ref6 = me_pair.ref_px[7:2];
  assign ad = cur6 > ref6 ? cur6 - ref6 : ref6 - cur6;
  // 256 x 63 stays below 2^14, so no saturation needed
  assign cand_sum = acc_q + {8'h00, ad};

  // Sequencer, one macroblock at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: if (mb_start) state_q <= S_SRCH;
        S_SRCH: begin
          if (cand_end && cand_q == `MCMD_CAND_LAST) state_q <= S_VAR;
        end
        S_VAR: begin
          if (rd_vld_q && var_cnt_q == `MCMD_VAR_DONE) state_q <= S_DEC;
        end
        S_DEC: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Candidate sums, best fit and zero-displacement fit
  always_ff @(posedge aclk) begin
    if (!aresetn || mb_go) begin
      pix_cnt_q <= 8'h00;
      cand_q <= 8'h00;
      acc_q <= 14'h0000;
      best_q <= `MCMD_BEST_INIT;
      best_idx_q <= 8'h00;
      zero_q <= 14'h0000;
      sum_cur_q <= 16'h0000;
    end else if (take) begin
      pix_cnt_q <= pix_cnt_q + 8'h01;
      acc_q <= cand_end ? 14'h0000 : cand_sum;
      if (cand_end) begin
        cand_q <= cand_q + 8'h01;
        // Strict compare keeps the earliest of equal fits
        if (cand_sum < best_q) begin
          best_q <= cand_sum;
          best_idx_q <= cand_q;
        end
        if (cand_q == `MCMD_ZERO_CAND) zero_q <= cand_sum;
      end
      if (cand_q == 8'h00) sum_cur_q <= sum_cur_q + {8'h00, me_pair.cur};
    end
  end

  // ****************************************************
  // Simplified variance
  // ****************************************************
  // Current block is kept from the first candidate pass
  mcmd_pix_mem u_mem (
    .aclk(aclk),
    .we(take && cand_q == 8'h00),
    .waddr(pix_cnt_q),
    .wdata(me_pair.cur),
    .raddr(var_cnt_q[7:0]),
    .rdata_q(mem_rd)
  );

  assign mean = sum_cur_q[15:8];
  assign vd = mem_rd > mean ? mem_rd - mean : mean - mem_rd;
  assign var14 = var_acc_q[15:2];

  // Second pass over stored pixels against the mean
  always_ff @(posedge aclk) begin
    if (!aresetn || mb_go) begin
      var_cnt_q <= 9'h000;
      rd_vld_q <= 1'b0;
      var_acc_q <= 16'h0000;
    end else if (state_q == S_VAR) begin
      rd_vld_q <= var_cnt_q != `MCMD_VAR_DONE;
      if (var_cnt_q != `MCMD_VAR_DONE) var_cnt_q <= var_cnt_q + 9'h001;
      if (rd_vld_q) var_acc_q <= var_acc_q + {8'h00, vd};
    end
  end

  // ****************************************************
  // Mode decision
  // ****************************************************
  // Boundary line: gap must reach an eighth of zero error plus offset
  always_comb begin
    zero_gap = zero_q - best_q;
    mc_w = zero_q > best_q && zero_gap >=
           (zero_q >> `MCMD_MC_SHIFT) + `MCMD_MC_OFS;
    sel_w = mc_w ? best_q : zero_q;
    comp_inter_w = sel_w[13:6] < thresh_q || var14 >= sel_w;
    fi_dis_w = ctrl_q.fix_mb || ctrl_q.skip_pic;
    periodic_w = !fi_dis_w &&
                 mb_cnt_q == 6'(`MCMD_INTRA_PERIOD - 6'h01);
    if (ctrl_q.force_inter) begin
      intra_w = 1'b0;
    end else if (ctrl_q.force_intra || periodic_w) begin
      intra_w = 1'b1;
    end else begin
      intra_w = !comp_inter_w;
    end
  end

  // Registered result, pulse on completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dec_valid <= 1'b0;
      dec_q <= '0;
    end else begin
      dec_valid <= state_q == S_DEC;
      if (state_q == S_DEC) begin
        dec_q.intra <= intra_w;
        dec_q.mc <= mc_w && !intra_w;
        dec_q.filt <= mc_w && !intra_w && !ctrl_q.filt_off;
        dec_q.mv_y <= best_idx_q[7:4] - `MCMD_VY_OFS;
        dec_q.mv_x <= best_idx_q[3:0] - `MCMD_VX_OFS;
        dec_q.best <= best_q;
        dec_q.zero <= zero_q;
        dec_q.sel <= sel_w;
        dec_q.var_e <= var14;
      end
    end
  end

  // Periodic intra counter, frozen by fix or skip
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mb_cnt_q <= 6'h00;
    end else if (state_q == S_DEC && !fi_dis_w) begin
      mb_cnt_q <= periodic_w ? 6'h00 : mb_cnt_q + 6'h01;
    end
  end

  // Filter follows the latest decision; bypass is the edge kernel
  mcmd_loop_filt u_filt (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(lf_valid),
    .win(lf_win),
    .edge_h(lf_edge_h || !dec_q.filt),
    .edge_v(lf_edge_v || !dec_q.filt),
    .out_valid_q(lf_out_valid),
    .pix_q(lf_pix)
  );

  // ****************************************************
  // Registers: AXI4-Lite and host byte port
  // ****************************************************
  logic aw_q, w_q, wr_fire, stb_q, hp_rise, hrd_q, hw_data;
  logic [4:0] awaddr_q;
  logic [31:0] wdata_q, hword;
  logic [3:0] wstrb_q;
  logic [2:0] ptr_q;

  function automatic logic [31:0] reg_word(input logic [4:0] a);
    case (a)
      `MCMD_OFS_CTRL: reg_word = {27'h0000000, ctrl_q};
      `MCMD_OFS_THR: reg_word = {24'h000000, thresh_q};
      `MCMD_OFS_RES: reg_word = {21'h000000, dec_q.intra, dec_q.mc,
                                 dec_q.filt, dec_q.mv_y, dec_q.mv_x};
      `MCMD_OFS_ERR: reg_word = {2'h0, dec_q.zero, 2'h0, dec_q.best};
      `MCMD_OFS_VAR: reg_word = {10'h000, mb_cnt_q, 2'h0, dec_q.var_e};
      default: reg_word = 32'h00000000;
    endcase
  endfunction

  function automatic logic hit(input logic [4:0] a);
    hit = a == `MCMD_OFS_CTRL || a == `MCMD_OFS_THR ||
          a == `MCMD_OFS_RES || a == `MCMD_OFS_ERR || a == `MCMD_OFS_VAR;
  endfunction

  assign awready = !aw_q;
  assign wready = !w_q;
  assign arready = !rvalid;
  assign wr_fire = aw_q && w_q && !bvalid;
  // Strobe is sampled; only its rising edge with enable counts
  assign hp_rise = host_ctrl_strobe && !stb_q && host_ctrl_enable;
  assign hw_data = hp_rise && host_data_not_instr && !hrd_q;
  always_comb hword = reg_word({ptr_q, 2'h0});
  assign host_ctrl_bus_oe = host_ctrl_enable && host_data_not_instr && hrd_q;

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `MCMD_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= hit(awaddr_q) ? `MCMD_RESP_OKAY : `MCMD_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel, answer one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `MCMD_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= reg_word(araddr);
      rresp <= hit(araddr) ? `MCMD_RESP_OKAY : `MCMD_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Host byte port: instruction picks register and direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stb_q <= 1'b0;
      ptr_q <= 3'h0;
      hrd_q <= 1'b0;
      host_ctrl_bus_out <= 8'h00;
    end else begin
      stb_q <= host_ctrl_strobe;
      if (hp_rise && !host_data_not_instr) begin
        ptr_q <= host_ctrl_bus_in[2:0];
        hrd_q <= host_ctrl_bus_in[`MCMD_HI_RD_BIT];
      end
      if (hp_rise && host_data_not_instr && hrd_q) begin
        host_ctrl_bus_out <= hword[7:0];
      end
    end
  end

  // Control and threshold; host byte wins a same-cycle AXI write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= mcmd_ctrl_t'(`MCMD_CTRL_RST);
      thresh_q <= `MCMD_THR_RST;
    end else begin
      if (hw_data && {ptr_q, 2'h0} == `MCMD_OFS_CTRL) begin
        ctrl_q <= mcmd_ctrl_t'(host_ctrl_bus_in[4:0]);
      end else if (wr_fire && wstrb_q[0] && awaddr_q == `MCMD_OFS_CTRL) begin
        ctrl_q <= mcmd_ctrl_t'(wdata_q[4:0]);
      end
      if (hw_data && {ptr_q, 2'h0} == `MCMD_OFS_THR) begin
        thresh_q <= host_ctrl_bus_in;
      end else if (wr_fire && wstrb_q[0] && awaddr_q == `MCMD_OFS_THR) begin
        thresh_q <= wdata_q[7:0];
      end
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_var_end;
    state_q == S_VAR && rd_vld_q && var_cnt_q == `MCMD_VAR_DONE;
  endsequence
  sequence s_dec_out;
    state_q == S_DEC ##1 (dec_valid && state_q == S_IDLE);
  endsequence
  property p_finish;
    s_var_end |=> s_dec_out;
  endproperty
  a_finish: assert property (p_finish)
    else $error("decision not issued after variance");

  property p_search_end;
    cand_end && cand_q == `MCMD_CAND_LAST |=> state_q == S_VAR;
  endproperty
  a_search_end: assert property (p_search_end)
    else $error("search did not end after last candidate");

  property p_force_inter;
    state_q == S_DEC && ctrl_q.force_inter |=> !dec_q.intra && dec_valid;
  endproperty
  a_force_inter: assert property (p_force_inter)
    else $error("host forced inter not honoured");

  property p_periodic;
    state_q == S_DEC && !ctrl_q.force_inter && periodic_w
      |=> dec_q.intra && mb_cnt_q == 6'h00;
  endproperty
  a_periodic: assert property (p_periodic)
    else $error("periodic intra missing");

  property p_cnt_hold;
    state_q == S_DEC && fi_dis_w |=> $stable(mb_cnt_q);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold)
    else $error("intra counter moved while disabled");

  property p_thr;
    state_q == S_DEC && !ctrl_q.force_intra && !periodic_w &&
      sel_w[13:6] < thresh_q |=> !dec_q.intra;
  endproperty
  a_thr: assert property (p_thr)
    else $error("below threshold not coded inter");

  property p_var;
    state_q == S_DEC && !ctrl_q.force_inter && sel_w[13:6] >= thresh_q
      && var14 < sel_w |=> dec_q.intra;
  endproperty
  a_var: assert property (p_var)
    else $error("low variance not coded intra");

  property p_sel;
    state_q == S_DEC && mc_w |=> dec_q.sel == $past(best_q);
  endproperty
  a_sel: assert property (p_sel)
    else $error("compensated error not selected");

  property p_filt;
    dec_valid && dec_q.filt |-> dec_q.mc && !dec_q.intra;
  endproperty
  a_filt: assert property (p_filt)
    else $error("filter on without compensated inter");

  property p_host_thr;
    hw_data && ptr_q == 3'h1 |=> thresh_q == $past(host_ctrl_bus_in);
  endproperty
  a_host_thr: assert property (p_host_thr)
    else $error("host data byte not stored");
endmodule

// File: tb/mcmd_host_model.sv
`timescale 1ns/1ns
module mcmd_host_model (
  // Clock
  input wire logic aclk,
  // Device side of the control bus
  input wire logic [7:0] dev_out,
  input wire logic dev_oe,
  // Host side
  output logic [7:0] bus_in,
  output logic strobe,
  output logic enable,
  output logic dni
);
  logic [7:0] hv;
  logic hoe;
  // Released bus shows the inverse, so a stale byte never passes
  assign bus_in = dev_oe ? dev_out : (hoe ? hv : ~hv);
  // Idle levels
  initial begin
    hv = 8'h00;
    hoe = 1'b1;
    strobe = 1'b0;
    enable = 1'b0;
    dni = 1'b0;
  end
  // One byte: strobe low for a sample, then one rising strobe
  task automatic xfer(input logic d, input logic [7:0] b, input logic rd);
    @(posedge aclk);
    enable <= 1'b1;
    dni <= d;
    hoe <= !rd;
    hv <= b;
    @(posedge aclk);
    strobe <= 1'b1;
    @(posedge aclk);
    strobe <= 1'b0;
    @(posedge aclk);
  endtask
  // Instruction then data byte
  task automatic host_write(input logic [2:0] idx, input logic [7:0] v);
    xfer(1'b0, {5'h00, idx}, 1'b0);
    xfer(1'b1, v, 1'b0);
  endtask
  // Read mode instruction, then a data strobe with the bus released
  task automatic host_read(input logic [2:0] idx, output logic [7:0] v);
    xfer(1'b0, {1'b1, 4'h0, idx}, 1'b0);
    xfer(1'b1, 8'h00, 1'b1);
    @(posedge aclk);
    v = bus_in;
    enable <= 1'b0;
    hoe <= 1'b1;
    @(posedge aclk);
  endtask
endmodule

// File: tb/mcmd_top_bench.sv
`timescale 1ns/1ns
`include "mcmd_cfg.svh"
module mcmd_top_bench;
  import mcmd_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, mb_start, me_valid, me_ready;
  logic dec_valid, lf_valid, lf_edge_h, lf_edge_v, lf_out_valid;
  logic hb_oe, h_stb, h_en, h_dni, filt_act;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] lf_pix, hb_in, hb_out, hv;
  logic [7:0] cur[256];
  mcmd_pair_t me_pair;
  mcmd_dec_t dec_q;
  mcmd_win_t lf_win;
  int fail_count, num_checks;
  logic [33:0] q_rd[$];
  logic [1:0] q_b[$];
  logic [7:0] q_lf[$];
  mcmd_dec_t q_dec[$];
  mcmd_top mcmd_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .mb_start(mb_start), .me_valid(me_valid), .me_pair(me_pair),
    .me_ready(me_ready), .dec_valid(dec_valid), .dec_q(dec_q),
    .lf_valid(lf_valid), .lf_win(lf_win), .lf_edge_h(lf_edge_h),
    .lf_edge_v(lf_edge_v), .lf_out_valid(lf_out_valid), .lf_pix(lf_pix),
    .host_ctrl_bus_in(hb_in), .host_ctrl_bus_out(hb_out),
    .host_ctrl_bus_oe(hb_oe), .host_ctrl_strobe(h_stb),
    .host_ctrl_enable(h_en), .host_data_not_instr(h_dni));
  mcmd_host_model mcmd_host_model_i (.aclk(aclk), .dev_out(hb_out),
    .dev_oe(hb_oe), .bus_in(hb_in), .strobe(h_stb), .enable(h_en),
    .dni(h_dni));
  // 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic check(string n, logic [76:0] e, logic [76:0] g);
    num_checks++;
    if (e !== g) begin
      $display("unexpected %s exp %h got %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic guard(int n, int lim);
    if (n >= lim) begin
      $display("unexpected timeout");
      fail_count++;
      finish_test();
    end
  endtask
  // ****************************************************
  // Result watcher
  // ****************************************************
  // Each result is matched against the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) check("read", q_rd.pop_front(), {rresp, rdata});
    if (bvalid && bready) check("bresp", q_b.pop_front(), bresp);
    if (lf_out_valid) check("lf_pix", q_lf.pop_front(), lf_pix);
    if (dec_valid) check("dec_q", q_dec.pop_front(), dec_q);
  end
  // ****************************************************
  // Bus tasks
  // ****************************************************
  task automatic wr(logic [4:0] a, logic [31:0] d, logic [1:0] r);
    int n;
    n = 0;
    q_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (((awvalid && !awready) || (wvalid && !wready)) && n < 50);
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    guard(n, 50);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(logic [4:0] a, logic [33:0] e);
    int n;
    n = 0;
    q_rd.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    guard(n, 50);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // ****************************************************
  // Stream tasks
  // ****************************************************
  function automatic logic [7:0] lf_exp(mcmd_win_t w, logic eh, logic ev);
    int h[3];
    for (int r = 0; r < 3; r++) begin
      h[r] = eh ? 4 * w[r*3+1] : w[r*3] + 2 * w[r*3+1] + w[r*3+2];
    end
    return 8'(((ev ? 4 * h[1] : h[0] + 2 * h[1] + h[2]) + 8) >> 4);
  endfunction
  // Back-to-back windows; edges forced while filtering is off
  task automatic lf_run();
    mcmd_win_t w;
    logic eh, ev;
    for (int k = 0; k < 12; k++) begin
      for (int j = 0; j < 9; j++) w[j] = 8'($urandom);
      eh = filt_act ? 1'($urandom) : 1'b1;
      ev = filt_act ? 1'($urandom) : 1'b1;
      q_lf.push_back(lf_exp(w, eh, ev));
      lf_win <= w;
      lf_edge_h <= eh;
      lf_edge_v <= ev;
      lf_valid <= 1'b1;
      @(posedge aclk);
    end
    lf_valid <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  // Candidate 0 matches exactly, all others see a black reference
  task automatic run_mb(logic [7:0] thr);
    int s, m, v, n;
    mcmd_dec_t e;
    s = 0;
    m = 0;
    v = 0;
    for (int i = 0; i < 256; i++) cur[i] = 8'($urandom);
    for (int i = 0; i < 256; i++) m += cur[i];
    for (int i = 0; i < 256; i++) s += cur[i] >> 2;
    for (int i = 0; i < 256; i++) v += (cur[i] > m / 256) ?
      cur[i] - m / 256 : m / 256 - cur[i];
    e = '0;
    e.zero = 14'(s);
    e.mc = s >= (s >> 3) + 16;
    e.sel = e.mc ? 14'h0000 : e.zero;
    e.var_e = 14'(v >> 2);
    e.intra = !(e.sel[13:6] < thr) && (e.var_e < e.sel);
    e.filt = e.mc && !e.intra;
    e.mv_y = 4'h9;
    e.mv_x = 4'h8;
    q_dec.push_back(e);
    filt_act = e.filt;
    mb_start <= 1'b1;
    for (int c = 0; c < 240; c++) begin
      for (int p = 0; p < 256; p++) begin
        me_pair <= {cur[p], (c == 0) ? cur[p] : 8'h00};
        me_valid <= 1'b1;
        n = 0;
        do begin
          @(posedge aclk);
          n++;
        end while (me_ready !== 1'b1 && n < 10);
        guard(n, 10);
        mb_start <= 1'b0;
      end
    end
    me_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (dec_valid !== 1'b1 && n < 400);
    guard(n, 400);
    rd(`MCMD_OFS_RES, {2'h0, 21'h0, e.intra, e.mc, e.filt, 8'h98});
    rd(`MCMD_OFS_ERR, {4'h0, e.zero, 2'h0, e.best});
    // Fix is set, so the intra counter must still read zero
    rd(`MCMD_OFS_VAR, {2'h0, 10'h000, 6'h00, 2'h0, e.var_e});
  endtask
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {mb_start, me_valid, lf_valid, lf_edge_h, lf_edge_v} = '0;
    {awaddr, araddr, wdata, me_pair, lf_win} = '0;
    wstrb = 4'hF;
    fail_count = 0;
    num_checks = 0;
    filt_act = 1'b0;
    void'($urandom(32'h32B9));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`MCMD_OFS_CTRL, 34'h0);
    rd(`MCMD_OFS_THR, {2'h0, 24'h0, `MCMD_THR_RST});
    rd(5'h14, {`MCMD_RESP_SLVERR, 32'h0});
    wr(5'h14, 32'h0000_0001, `MCMD_RESP_SLVERR);
    wr(`MCMD_OFS_THR, 32'h0000_0015, `MCMD_RESP_OKAY);
    rd(`MCMD_OFS_THR, 34'h15);
    mcmd_host_model_i.host_write(3'h1, 8'h20);
    rd(`MCMD_OFS_THR, 34'h20);
    mcmd_host_model_i.host_read(3'h1, hv);
    check("host byte", 77'h20, 77'(hv));
    // Host forces inter and fixes the macroblock for the search run
    wr(`MCMD_OFS_CTRL, 32'h0000_0005, `MCMD_RESP_OKAY);
    rd(`MCMD_OFS_CTRL, 34'h05);
    lf_run();
    run_mb(8'h20);
    lf_run();
    finish_test();
  end
endmodule
